// File: rtl/mcs_defs.svh
`ifndef MCS_DEFS_SVH
`define MCS_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define MCS_OFS_LOWER 8'h05
`define MCS_OFS_UPPER 8'h06
`define MCS_OFS_GEN 8'h07
`define MCS_OFS_FUSE 8'h08
`define MCS_OFS_CTRL 8'h0a
`define MCS_OFS_STAT 8'h0b
`define MCS_OFS_RESULT 8'h20
`define MCS_RES_LAST 8'h3c
// ----------------------------------------
// reset values and write masks
// ----------------------------------------
`define MCS_LOWER_RST 16'hffff
`define MCS_UPPER_RST 16'h0001
`define MCS_GEN_RST 16'h0001
`define MCS_FUSE_RST 16'h0000
`define MCS_CTRL_RST 16'h0000
`define MCS_UPPER_WMASK 16'h003f
`define MCS_GEN_WMASK 16'hf1ff
`define MCS_CTRL_WMASK 16'h003e
`define MCS_WORD_ZERO 16'h0000
// ----------------------------------------
// field positions
// ----------------------------------------
`define MCS_UP_CELL17 0
`define MCS_GEN_PACK 0
`define MCS_GEN_TH_LO 1
`define MCS_GEN_TH_HI 5
`define MCS_GEN_MID 6
`define MCS_GEN_PIN1 7
`define MCS_GEN_PIN2 8
`define MCS_GEN_CORE 12
`define MCS_GEN_EXT 13
`define MCS_GEN_VREF2 14
`define MCS_FUSE_VOLT 8
`define MCS_FUSE_CURR 0
`define MCS_CTRL_START 0
`define MCS_CTRL_CONT 1
`define MCS_CTRL_P1_OD 2
`define MCS_CTRL_P1_IE 3
`define MCS_CTRL_P2_OD 4
`define MCS_CTRL_P2_IE 5
`define MCS_STAT_BUSY 0
`define MCS_STAT_PAD 7'h00
// ----------------------------------------
// channels
// ----------------------------------------
`define MCS_CHANS 29
`define MCS_CH_CELL17 5'h10
`define MCS_CH_VREF2 5'h1c
`define MCS_CNT_ZERO 8'h00
`define MCS_CNT_ONE 8'h01
`endif

// File: rtl/mcs_pkg.sv
`include "mcs_defs.svh"
package mcs_pkg;
   typedef enum logic [1:0] {
      MCS_IDLE = 2'b00,
      MCS_PICK = 2'b01,
      MCS_CONV = 2'b11
   } mcs_state_type;
   typedef logic [`MCS_CHANS-1:0] mcs_mask_type;
endpackage : mcs_pkg

// File: rtl/mcs_chan_scan.sv
`timescale 1ns/1ps
`include "mcs_defs.svh"
module mcs_chan_scan (
   input wire mcs_pkg::mcs_mask_type mask,
   output logic found,
   output logic [4:0] index
);
   // lowest numbered pending channel goes first
   always_comb begin
      found = 1'b0;
      index = 5'h00;
      for (int i = `MCS_CHANS - 1; i >= 0; i--) begin
         if (mask[i]) begin
            found = 1'b1;
            index = 5'(i);
         end
      end
   end
endmodule : mcs_chan_scan

// File: rtl/mcs_result_store.sv
`timescale 1ns/1ps
`include "mcs_defs.svh"
module mcs_result_store (
   input wire logic clk,
   input wire logic rst,
   input wire logic we,
   input wire logic [4:0] waddr,
   input wire logic [15:0] wdata,
   input wire logic [4:0] raddr,
   output logic [15:0] rdata
);
   logic [15:0] mem [0:`MCS_CHANS-1];

   // a word only changes when its own channel finishes
   for (genvar g = 0; g < `MCS_CHANS; g++) begin : g_word
      always_ff @(posedge clk) begin
         if (rst) begin
            mem[g] <= `MCS_WORD_ZERO;
         end else if (we && waddr == 5'(g)) begin
            mem[g] <= wdata;
         end
      end
   end

   always_comb begin
      rdata = `MCS_WORD_ZERO;
      if (raddr < 5'(`MCS_CHANS)) begin
         rdata = mem[raddr];
      end
   end
endmodule : mcs_result_store

// File: rtl/mcs_top.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "mcs_defs.svh"
// Behaviour
// - cell seventeen converted only while upper select bit 0 is one; resets one
// - pack voltage measured only while general bit 0 is one; resets one
// - general bit 14 switches second reference monitor; resets zero
// - general bit 13 switches external regulator measurement; resets zero
// - general bit 12 switches core supply monitor; resets zero
// - general bit 6 switches mid supply monitor; resets zero
// - general bits 1 to 5 switch thermistors one to five; reset zero
// - general bit 7 switches pin one analog measurement; resets zero
// - general bit 8 switches pin two analog measurement; resets zero
// - lower select bits 15 to 0 switch cells 16 to 1; reset one
// - fuse bit 8 voltage monitor, bit 0 current monitor; reset off
module mcs_top (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WR_DATA,
   input wire logic WR_EN,
   input wire logic RD_EN,
   output logic [15:0] RD_DATA,
   output logic CONV_REQ,
   output logic [4:0] CONV_CHAN,
   input wire logic CONV_DONE,
   input wire logic [15:0] CONV_DATA,
   output logic BUSY,
   output logic CYCLE_DONE,
   output logic [28:0] MEASURE_ON,
   output logic [15:0] FUSE_CONTROL_ONE,
   output logic FUSE_VOLTAGE_MONITOR_ENABLE,
   output logic FUSE_CURRENT_MONITOR_ENABLE,
   output logic PIN_ONE_OUTPUT_DISABLE,
   output logic PIN_ONE_INPUT_ENABLE,
   output logic PIN_TWO_OUTPUT_DISABLE,
   output logic PIN_TWO_INPUT_ENABLE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   // ----------------------------------------
   // register file
   // ----------------------------------------
   logic [15:0] cell_select_lower;
   logic [15:0] cell_select_upper;
   logic [15:0] general_channel_select;
   logic [15:0] fuse_control_one;
   logic [15:0] ctrl;
   logic [7:0] cycle_count;
   mcs_pkg::mcs_state_type state;
   mcs_pkg::mcs_mask_type cycle_mask;
   mcs_pkg::mcs_mask_type pending;
   logic found;
   logic [4:0] index;
   logic [15:0] res_rdata;
   logic res_we;
   logic start_go;

   function automatic logic wr_hit(input logic [7:0] ofs);
      wr_hit = WR_EN && (ADDR == ofs);
   endfunction : wr_hit

   function automatic logic in_results(input logic [7:0] a);
      in_results = (a >= `MCS_OFS_RESULT) && (a <= `MCS_RES_LAST);
   endfunction : in_results

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cell_select_lower <= `MCS_LOWER_RST;
      end else if (wr_hit(`MCS_OFS_LOWER)) begin
         cell_select_lower <= WR_DATA;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cell_select_upper <= `MCS_UPPER_RST;
      end else if (wr_hit(`MCS_OFS_UPPER)) begin
         cell_select_upper <= WR_DATA & `MCS_UPPER_WMASK;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         general_channel_select <= `MCS_GEN_RST;
      end else if (wr_hit(`MCS_OFS_GEN)) begin
         general_channel_select <= WR_DATA & `MCS_GEN_WMASK;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         fuse_control_one <= `MCS_FUSE_RST;
      end else if (wr_hit(`MCS_OFS_FUSE)) begin
         fuse_control_one <= WR_DATA;
      end
   end

   // start bit is a strobe and is never stored
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ctrl <= `MCS_CTRL_RST;
      end else if (wr_hit(`MCS_OFS_CTRL)) begin
         ctrl <= WR_DATA & `MCS_CTRL_WMASK;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         RD_DATA <= `MCS_WORD_ZERO;
      end else if (RD_EN) begin
         case (ADDR)
            `MCS_OFS_LOWER: begin
               RD_DATA <= cell_select_lower;
            end
            `MCS_OFS_UPPER: begin
               RD_DATA <= cell_select_upper;
            end
            `MCS_OFS_GEN: begin
               RD_DATA <= general_channel_select;
            end
            `MCS_OFS_FUSE: begin
               RD_DATA <= fuse_control_one;
            end
            `MCS_OFS_CTRL: begin
               RD_DATA <= ctrl;
            end
            `MCS_OFS_STAT: begin
               RD_DATA <= {cycle_count, `MCS_STAT_PAD, BUSY};
            end
            default: begin
               RD_DATA <= in_results(ADDR) ? res_rdata : `MCS_WORD_ZERO;
            end
         endcase
      end else begin
         RD_DATA <= `MCS_WORD_ZERO;
      end
   end

   // ----------------------------------------
   // select outputs
   // ----------------------------------------
   // cells one to sixteen
   assign MEASURE_ON[15:0] = cell_select_lower;
   assign MEASURE_ON[16] = cell_select_upper[`MCS_UP_CELL17];
   assign MEASURE_ON[17] = general_channel_select[`MCS_GEN_PACK];
   assign MEASURE_ON[22:18] = general_channel_select[`MCS_GEN_TH_HI:`MCS_GEN_TH_LO];
   assign MEASURE_ON[23] = general_channel_select[`MCS_GEN_MID];
   assign MEASURE_ON[24] = general_channel_select[`MCS_GEN_PIN1];
   assign MEASURE_ON[25] = general_channel_select[`MCS_GEN_PIN2];
   assign MEASURE_ON[26] = general_channel_select[`MCS_GEN_CORE];
   assign MEASURE_ON[27] = general_channel_select[`MCS_GEN_EXT];
   assign MEASURE_ON[28] = general_channel_select[`MCS_GEN_VREF2];

   assign FUSE_CONTROL_ONE = fuse_control_one;
   assign FUSE_VOLTAGE_MONITOR_ENABLE = fuse_control_one[`MCS_FUSE_VOLT];
   assign FUSE_CURRENT_MONITOR_ENABLE = fuse_control_one[`MCS_FUSE_CURR];
   // the pin bits are not interlocked with the analog selects: software orders them
   assign PIN_ONE_OUTPUT_DISABLE = ctrl[`MCS_CTRL_P1_OD];
   assign PIN_ONE_INPUT_ENABLE = ctrl[`MCS_CTRL_P1_IE];
   assign PIN_TWO_OUTPUT_DISABLE = ctrl[`MCS_CTRL_P2_OD];
   assign PIN_TWO_INPUT_ENABLE = ctrl[`MCS_CTRL_P2_IE];

   // ----------------------------------------
   // measurement sequencer
   // ----------------------------------------
   assign start_go = (state == mcs_pkg::MCS_IDLE) &&
                     ((wr_hit(`MCS_OFS_CTRL) && WR_DATA[`MCS_CTRL_START]) ||
                      ctrl[`MCS_CTRL_CONT]);
   assign BUSY = (state != mcs_pkg::MCS_IDLE);
   assign res_we = (state == mcs_pkg::MCS_CONV) && CONV_DONE;

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state <= mcs_pkg::MCS_IDLE;
      end else begin
         case (state)
            mcs_pkg::MCS_IDLE: begin
               if (start_go) begin
                  state <= mcs_pkg::MCS_PICK;
               end
            end
            mcs_pkg::MCS_PICK: begin
               state <= found ? mcs_pkg::MCS_CONV : mcs_pkg::MCS_IDLE;
            end
            mcs_pkg::MCS_CONV: begin
               if (CONV_DONE) begin
                  state <= mcs_pkg::MCS_PICK;
               end
            end
            default: begin
               state <= mcs_pkg::MCS_IDLE;
            end
         endcase
      end
   end

   // snapshot per cycle
   // selects written mid cycle wait for the next cycle so a sweep stays coherent
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cycle_mask <= '0;
         pending <= '0;
      end else if (start_go) begin
         cycle_mask <= MEASURE_ON;
         pending <= MEASURE_ON;
      end else if (state == mcs_pkg::MCS_PICK && found) begin
         pending[index] <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         CONV_REQ <= 1'b0;
         CONV_CHAN <= 5'h00;
      end else begin
         CONV_REQ <= (state == mcs_pkg::MCS_PICK) && found;
         if (state == mcs_pkg::MCS_PICK && found) begin
            CONV_CHAN <= index;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cycle_count <= `MCS_CNT_ZERO;
         CYCLE_DONE <= 1'b0;
      end else begin
         CYCLE_DONE <= (state == mcs_pkg::MCS_PICK) && !found;
         if (state == mcs_pkg::MCS_PICK && !found) begin
            cycle_count <= cycle_count + `MCS_CNT_ONE;
         end
      end
   end

   mcs_chan_scan u_scan (
      .mask(pending),
      .found(found),
      .index(index)
   );

   mcs_result_store u_store (
      .clk(CLK),
      .rst(SYS_RST),
      .we(res_we),
      .waddr(CONV_CHAN),
      .wdata(CONV_DATA),
      .raddr(5'(ADDR - `MCS_OFS_RESULT)),
      .rdata(res_rdata)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_REQ_SELECTED: assert property (CONV_REQ |-> cycle_mask[CONV_CHAN])
      else $error("conversion requested for a deselected channel");
   AST_WRITE_SELECTED: assert property (res_we |-> cycle_mask[CONV_CHAN])
      else $error("result written for a deselected channel");
   AST_MASK_HELD: assert property (BUSY |=> $stable(cycle_mask))
      else $error("select snapshot changed inside a cycle");
   AST_UPPER_RESET: assert property (
      $fell(SYS_RST) |-> cell_select_upper == `MCS_UPPER_RST)
      else $error("upper cell select reset value wrong");
   AST_CELL17_SKIP: assert property (
      (start_go && !cell_select_upper[`MCS_UP_CELL17]) |=>
      (CONV_CHAN != `MCS_CH_CELL17 || !CONV_REQ) [*8])
      else $error("cell seventeen converted while deselected");
   AST_GEN_RESET: assert property (
      $fell(SYS_RST) |-> general_channel_select == `MCS_GEN_RST)
      else $error("general select reset value wrong");
   AST_LOWER_RESET: assert property (
      $fell(SYS_RST) |-> cell_select_lower == `MCS_LOWER_RST)
      else $error("lower cell select reset value wrong");
   AST_FUSE_RESET: assert property ($fell(SYS_RST) |-> !FUSE_VOLTAGE_MONITOR_ENABLE &&
      !FUSE_CURRENT_MONITOR_ENABLE)
      else $error("fuse monitors enabled after reset");
   AST_UNUSED_ZERO: assert property (
      WR_EN |=> (general_channel_select & ~`MCS_GEN_WMASK) == `MCS_WORD_ZERO &&
      (cell_select_upper & ~`MCS_UPPER_WMASK) == `MCS_WORD_ZERO)
      else $error("unassigned select bits not zero");
   AST_VREF2_SNAP: assert property (
      start_go |=> cycle_mask[`MCS_CH_VREF2] == $past(general_channel_select[`MCS_GEN_VREF2]))
      else $error("second reference select not taken into cycle");
   AST_PICK_TO_REQ: assert property (
      (state == mcs_pkg::MCS_PICK && found) |=> CONV_REQ && CONV_CHAN == $past(index))
      else $error("picked channel not requested next cycle");

   // ----------------------------------------
   // sequencer and register checks
   // ----------------------------------------
   AST_REQ_PULSE: assert property (CONV_REQ |=> !CONV_REQ)
      else $error("conversion request longer than one cycle");
   AST_CHAN_HELD: assert property ($changed(CONV_CHAN) |-> CONV_REQ)
      else $error("conversion channel changed without a request");
   AST_SWEEP_END: assert property (
      (state == mcs_pkg::MCS_PICK && !found) |=> CYCLE_DONE && !BUSY)
      else $error("empty pick did not end the sweep");
   AST_DONE_TO_PICK: assert property (
      (state == mcs_pkg::MCS_CONV && CONV_DONE) |=> state == mcs_pkg::MCS_PICK)
      else $error("finished conversion did not return to pick");
   AST_SNAP_ALL: assert property (start_go |=> cycle_mask == $past(MEASURE_ON))
      else $error("sweep snapshot differs from the live selects");
   AST_RESET_IDLE: assert property (
      $fell(SYS_RST) |-> !BUSY && !CONV_REQ && !CYCLE_DONE)
      else $error("sequencer not idle after reset");

   AST_LOWER_KEEP: assert property (
      !(WR_EN && ADDR == `MCS_OFS_LOWER) |=> $stable(cell_select_lower))
      else $error("lower cell select changed without a write");
   AST_UPPER_KEEP: assert property (
      !(WR_EN && ADDR == `MCS_OFS_UPPER) |=> $stable(cell_select_upper))
      else $error("upper cell select changed without a write");
   AST_GEN_KEEP: assert property (
      !(WR_EN && ADDR == `MCS_OFS_GEN) |=> $stable(general_channel_select))
      else $error("general select changed without a write");
   AST_FUSE_KEEP: assert property (
      !(WR_EN && ADDR == `MCS_OFS_FUSE) |=> $stable(fuse_control_one))
      else $error("fuse control changed without a write");

   AST_UPPER_WRITE: assert property (
      (WR_EN && ADDR == `MCS_OFS_UPPER) |=>
      cell_select_upper == ($past(WR_DATA) & `MCS_UPPER_WMASK))
      else $error("upper cell select write not taken as masked");
   AST_GEN_WRITE: assert property (
      (WR_EN && ADDR == `MCS_OFS_GEN) |=>
      general_channel_select == ($past(WR_DATA) & `MCS_GEN_WMASK))
      else $error("general select write not taken as masked");
endmodule : mcs_top

// File: testbench/measurement_channel_select_tb.sv
`timescale 1ns/1ps
`include "mcs_defs.svh"
module measurement_channel_select_tb;
   logic clk;
   logic sys_rst;
   logic [7:0] addr;
   logic [15:0] wr_data;
   logic wr_en;
   logic rd_en;
   logic [15:0] rd_data;
   logic conv_req;
   logic [4:0] conv_chan;
   logic conv_done;
   logic [15:0] conv_data;
   logic busy;
   logic cycle_done;
   logic [28:0] measure_on;
   logic [15:0] fuse_word;
   logic fuse_volt;
   logic fuse_curr;
   logic p1_od;
   logic p1_ie;
   logic p2_od;
   logic p2_ie;
   int bad_count = 0;
   int tests_run = 0;

   mcs_top dut (
      .CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en),
      .RD_EN(rd_en), .RD_DATA(rd_data), .CONV_REQ(conv_req), .CONV_CHAN(conv_chan),
      .CONV_DONE(conv_done), .CONV_DATA(conv_data), .BUSY(busy), .CYCLE_DONE(cycle_done),
      .MEASURE_ON(measure_on), .FUSE_CONTROL_ONE(fuse_word),
      .FUSE_VOLTAGE_MONITOR_ENABLE(fuse_volt), .FUSE_CURRENT_MONITOR_ENABLE(fuse_curr),
      .PIN_ONE_OUTPUT_DISABLE(p1_od), .PIN_ONE_INPUT_ENABLE(p1_ie),
      .PIN_TWO_OUTPUT_DISABLE(p2_od), .PIN_TWO_INPUT_ENABLE(p2_ie)
   );

   // ----------------------------------------
   // clock, shared tasks
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task print_verdict;
      if (bad_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task rd_chk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk({16'h0000, rd_data}, {16'h0000, exp});
   endtask : rd_chk

   // waits bounded for a request, checks its channel, answers a cycle later
   task adc_serve(input logic [4:0] ch, input logic [15:0] d);
      int n;
      n = 0;
      while (conv_req !== 1'b1 && n < 50) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({31'h0, conv_req}, 32'h1);
      chk({27'h0, conv_chan}, {27'h0, ch});
      chk({31'h0, busy}, 32'h1);
      @(posedge clk);
      conv_done <= 1'b1;
      conv_data <= d;
      @(posedge clk);
      conv_done <= 1'b0;
      #1;
   endtask : adc_serve

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset_values;
      rd_chk(`MCS_OFS_LOWER, 16'hffff); // cells on
      rd_chk(`MCS_OFS_UPPER, 16'h0001); // cell seventeen on
      rd_chk(`MCS_OFS_GEN, 16'h0001); // gen
      rd_chk(`MCS_OFS_FUSE, 16'h0000); // fuse off
      chk({3'h0, measure_on}, 32'h0003ffff); // default map
      chk({30'h0, fuse_volt, fuse_curr}, 32'h0); // monitors off
   endtask : t_reset_values

   task t_general_map;
      int gb[12];
      int mi[12];
      logic [15:0] v;
      gb = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 12, 13, 14};
      mi = '{17, 18, 19, 20, 21, 22, 23, 24, 25, 26, 27, 28};
      // pin configuration precedes the analog selects
      wr(`MCS_OFS_CTRL, 16'h003c); // pins as inputs
      chk({28'h0, p1_od, p1_ie, p2_od, p2_ie}, 32'hf);
      for (int i = 0; i < 12; i++) begin
         v = 16'h0001 << gb[i];
         wr(`MCS_OFS_GEN, v);
         chk({3'h0, measure_on}, 32'h0001ffff | (32'h1 << mi[i])); // map
         rd_chk(`MCS_OFS_GEN, v); // readback
      end
   endtask : t_general_map

   task t_cells_and_reserved;
      wr(`MCS_OFS_LOWER, 16'h8001);
      wr(`MCS_OFS_UPPER, 16'h0000);
      wr(`MCS_OFS_GEN, 16'h0000);
      chk({3'h0, measure_on}, 32'h00008001); // only cells one and sixteen on
      wr(`MCS_OFS_GEN, 16'hffff);
      rd_chk(`MCS_OFS_GEN, 16'hf1ff); // gaps read zero
      wr(`MCS_OFS_UPPER, 16'hffff);
      rd_chk(`MCS_OFS_UPPER, 16'h003f); // upper gaps zero
      chk({31'h0, measure_on[16]}, 32'h1); // cell seventeen on
      rd_chk(8'h0c, 16'h0000);
   endtask : t_cells_and_reserved

   task t_fuse;
      wr(`MCS_OFS_FUSE, 16'h0101);
      chk({14'h0, fuse_volt, fuse_curr, fuse_word}, 32'h00030101); // both on
      wr(`MCS_OFS_FUSE, 16'hfefe);
      chk({14'h0, fuse_volt, fuse_curr, fuse_word}, 32'h0000fefe); // both off
      rd_chk(`MCS_OFS_FUSE, 16'hfefe); // readback
   endtask : t_fuse

   // only cell two and the second reference are converted
   task t_sweep;
      int n;
      wr(`MCS_OFS_LOWER, 16'h0002);
      wr(`MCS_OFS_UPPER, 16'h0000);
      wr(`MCS_OFS_GEN, 16'h4000);
      wr(`MCS_OFS_CTRL, 16'h003d);
      adc_serve(5'h01, 16'h1234); // lowest selected first
      adc_serve(`MCS_CH_VREF2, 16'h5678); // skips deselected
      n = 0;
      while (cycle_done !== 1'b1 && n < 10) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({31'h0, cycle_done}, 32'h1); // sweep ends
      @(posedge clk);
      #1;
      chk({30'h0, busy, conv_req}, 32'h0); // idle again
      rd_chk(`MCS_OFS_STAT, 16'h0100); // one sweep counted, idle
      rd_chk(`MCS_OFS_CTRL, 16'h003c); // start bit not kept
      rd_chk(`MCS_OFS_RESULT + 8'h01, 16'h1234); // stored
      rd_chk(`MCS_OFS_RESULT + 8'h1c, 16'h5678); // stored
      rd_chk(`MCS_OFS_RESULT, 16'h0000); // skipped kept
      rd_chk(`MCS_OFS_RESULT + 8'h10, 16'h0000); // skipped kept
   endtask : t_sweep

   // continuous sweeps; a select written while running waits for the sweep after
   task t_continuous;
      wr(`MCS_OFS_GEN, 16'h0000);
      wr(`MCS_OFS_CTRL, 16'h003e); // continuous, pins stay inputs
      adc_serve(5'h01, 16'h1111); // first sweep
      wr(`MCS_OFS_GEN, 16'h4000); // lands as the next sweep starts
      adc_serve(5'h01, 16'h2222); // old snapshot still used
      wr(`MCS_OFS_CTRL, 16'h003c); // stop after the sweep now starting
      adc_serve(5'h01, 16'h3333); // new snapshot
      adc_serve(`MCS_CH_VREF2, 16'h4444); // second reference converted
      rd_chk(`MCS_OFS_STAT, 16'h0400); // four sweeps, idle
      rd_chk(`MCS_OFS_RESULT + 8'h01, 16'h3333); // latest result
      rd_chk(`MCS_OFS_RESULT + 8'h1c, 16'h4444); // latest result
   endtask : t_continuous

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      sys_rst = 1'b1;
      addr = 8'h00;
      wr_data = 16'h0000;
      wr_en = 1'b0;
      rd_en = 1'b0;
      conv_done = 1'b0;
      conv_data = 16'h0000;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      t_reset_values();
      t_general_map();
      t_cells_and_reserved();
      t_fuse();
      t_sweep();
      t_continuous();
      print_verdict();
   end

   // the whole sequence needs under two hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      print_verdict();
   end
endmodule : measurement_channel_select_tb
